// ==== shared/ccd_map.svh ====
// constants for the clock domain distribution block
`ifndef CCD_MAP_SVH
`define CCD_MAP_SVH

// source-select fuse codes (fuse bit reads 1 when unprogrammed)
`define CCD_SRC_LP_XTAL_MIN 4'h8
`define CCD_SRC_FS_XTAL_MIN 4'h6
`define CCD_SRC_LF_XTAL_MIN 4'h4
`define CCD_SRC_RC128K 4'h3
`define CCD_SRC_RC_CAL 4'h2
`define CCD_SRC_RESERVED 4'h1
`define CCD_SRC_EXT 4'h0

// sleep mode field codes
`define CCD_SLP_IDLE 3'h0
`define CCD_SLP_ADC_NR 3'h1
`define CCD_SLP_PDOWN 3'h2
`define CCD_SLP_PSAVE 3'h3
`define CCD_SLP_STBY 3'h6
`define CCD_SLP_EXT_STBY 3'h7

// start-up counts in oscillator cycles
`define CCD_SU_EXT_CK 16'h0006
`define CCD_SU_258_CK 16'h0102
`define CCD_SU_1K_CK 16'h0400
`define CCD_SU_16K_CK 16'h4000
`define CCD_SU_32K_CK 16'h8000

// largest prescaler division exponent
`define CCD_PRESC_MAX 4'h8

`endif

// ==== shared/ccd_pkg.sv ====
// types of the clock domain distribution block
package ccd_pkg;

  typedef enum logic [2:0] {
    CCD_OSC_LP_XTAL = 3'h0,
    CCD_OSC_FS_XTAL = 3'h1,
    CCD_OSC_LF_XTAL = 3'h2,
    CCD_OSC_RC128K = 3'h3,
    CCD_OSC_RC_CAL = 3'h4,
    CCD_OSC_EXT = 3'h5
  } ccd_osc_t;

  typedef enum logic [1:0] {
    CCD_ST_ACTIVE = 2'h0,
    CCD_ST_SLEEP = 2'h1,
    CCD_ST_STARTUP = 2'h2
  } ccd_state_t;

  // which domains run
  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic adc;
    logic asy;
  } ccd_dom_t;

  // gated domain clocks
  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic adc;
    logic two_wire_serial_port;
  } ccd_clk_t;

endpackage : ccd_pkg

// ==== src/ccd_clock_dist.sv ====
// clock source decode, prescaler, sleep control and gated domain clocks
`timescale 1ns/1ps
`default_nettype none
`include "ccd_map.svh"

module ccd_clock_dist #(
  parameter int unsigned SU_16K_CYCLES = `CCD_SU_16K_CK,
  parameter int unsigned SU_32K_CYCLES = `CCD_SU_32K_CK
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // fuses, raw levels
  input wire logic [3:0] clock_source_select_fuses_i,
  input wire logic [1:0] startup_time_fuses_i,
  // prescaler and sleep control from the core
  input wire logic [3:0] prescale_sel_i,
  input wire logic sleep_req_i,
  input wire logic [2:0] sleep_mode_i,
  input wire logic async_timer_en_i,
  // pins
  input wire logic wake_pin_i,
  input wire logic level_irq_pin_i,
  input wire logic async_timer_domain_clock_i,
  // domain clocks and status
  output ccd_pkg::ccd_clk_t dom_clk_o,
  output logic async_timer_tick_o,
  output ccd_pkg::ccd_dom_t dom_run_o,
  output ccd_pkg::ccd_osc_t clock_source_o,
  output logic fuse_reserved_o,
  output logic usi_start_async_o,
  output logic level_irq_o,
  output logic asleep_o
);
  import ccd_pkg::*;

  // decode of source-select code as read from the fuses
  function automatic ccd_osc_t osc_decode(input logic [3:0] code);
    if (code >= `CCD_SRC_LP_XTAL_MIN) osc_decode = CCD_OSC_LP_XTAL;
    else if (code >= `CCD_SRC_FS_XTAL_MIN) osc_decode = CCD_OSC_FS_XTAL;
    else if (code >= `CCD_SRC_LF_XTAL_MIN) osc_decode = CCD_OSC_LF_XTAL;
    else if (code == `CCD_SRC_RC128K) osc_decode = CCD_OSC_RC128K;
    else if (code == `CCD_SRC_EXT) osc_decode = CCD_OSC_EXT;
    else osc_decode = CCD_OSC_RC_CAL;
  endfunction : osc_decode

  // domains kept running by a sleep mode
  function automatic ccd_dom_t sleep_domains(input logic [2:0] mode);
    ccd_dom_t d;
    d = '0;
    unique case (mode)
      `CCD_SLP_IDLE: d = '{cpu: 1'b0, flash: 1'b0, io: 1'b1, adc: 1'b1, asy: 1'b1};
      `CCD_SLP_ADC_NR: d = '{cpu: 1'b0, flash: 1'b0, io: 1'b0, adc: 1'b1, asy: 1'b1};
      `CCD_SLP_PSAVE, `CCD_SLP_EXT_STBY: d = '{cpu: 1'b0, flash: 1'b0, io: 1'b0, adc: 1'b0, asy: 1'b1};
      `CCD_SLP_PDOWN, `CCD_SLP_STBY: d = '0;
      default: d = '{cpu: 1'b0, flash: 1'b0, io: 1'b1, adc: 1'b1, asy: 1'b1};
    endcase
    sleep_domains = d;
  endfunction : sleep_domains

  // pin synchronisers
  logic [2:0] pin_raw;
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  assign pin_raw = {async_timer_domain_clock_i, level_irq_pin_i, wake_pin_i};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= pin_raw[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate
  logic wake_s;
  logic level_s;
  logic asy_s;
  assign wake_s = sync2_r[0];
  assign level_s = sync2_r[1];
  assign asy_s = sync2_r[2];

  // fuses caught at the first edge after reset release
  logic fuse_ld_r;
  logic [3:0] src_fuse_r;
  logic [1:0] sut_fuse_r;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fuse_ld_r <= 1'b0;
      src_fuse_r <= `CCD_SRC_RC_CAL;
      sut_fuse_r <= 2'h0;
    end else if (!fuse_ld_r) begin
      fuse_ld_r <= 1'b1;
      // bits kept as read: 1 unprogrammed, 0 programmed
      src_fuse_r <= clock_source_select_fuses_i;
      sut_fuse_r <= startup_time_fuses_i;
    end
  end

  ccd_osc_t osc;
  assign osc = osc_decode(src_fuse_r);
  assign clock_source_o = osc;
  // reserved code falls back to the calibrated rc and is flagged
  assign fuse_reserved_o = fuse_ld_r && (src_fuse_r == `CCD_SRC_RESERVED);

  // start-up length in cycles for the chosen source
  logic [15:0] su_len;
  always_comb begin
    su_len = `CCD_SU_EXT_CK;
    unique case (osc)
      CCD_OSC_LP_XTAL: begin
        if (!src_fuse_r[0] && sut_fuse_r <= 2'h1) su_len = `CCD_SU_258_CK;
        else if (!src_fuse_r[0] || sut_fuse_r == 2'h0) su_len = `CCD_SU_1K_CK;
        else su_len = SU_16K_CYCLES[15:0];
      end
      CCD_OSC_FS_XTAL: su_len = SU_16K_CYCLES[15:0];
      CCD_OSC_LF_XTAL: su_len = 16'(SU_32K_CYCLES - 1);
      CCD_OSC_RC128K, CCD_OSC_RC_CAL, CCD_OSC_EXT: su_len = `CCD_SU_EXT_CK;
    endcase
  end

  // system clock prescaler: one tick each 2^n reference cycles
  logic [7:0] presc_r;
  logic [7:0] presc_mask;
  logic sys_tick;
  logic [3:0] presc_exp;
  assign presc_exp = (prescale_sel_i > `CCD_PRESC_MAX) ? `CCD_PRESC_MAX : prescale_sel_i;
  assign presc_mask = 8'(9'h1ff >> (4'h9 - presc_exp));
  // one shared tick times every gated domain clock; the async timer tick follows its external clock
  assign sys_tick = ((presc_r & presc_mask) == presc_mask);
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) presc_r <= 8'h00;
    else presc_r <= presc_r + 8'h01;
  end

  // sleep state machine
  ccd_state_t state_r;
  logic [2:0] mode_r;
  logic [15:0] su_cnt_r;
  logic su_needed;
  assign su_needed = (mode_r == `CCD_SLP_PDOWN) || (mode_r == `CCD_SLP_PSAVE);
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= CCD_ST_ACTIVE;
      mode_r <= `CCD_SLP_IDLE;
      su_cnt_r <= 16'h0000;
    end else begin
      unique case (state_r)
        CCD_ST_ACTIVE: begin
          if (sleep_req_i) begin
            state_r <= CCD_ST_SLEEP;
            mode_r <= sleep_mode_i;
          end
        end
        CCD_ST_SLEEP: begin
          if (wake_s || level_s) begin
            su_cnt_r <= 16'h0000;
            state_r <= su_needed ? CCD_ST_STARTUP : CCD_ST_ACTIVE;
          end
        end
        CCD_ST_STARTUP: begin
          su_cnt_r <= su_cnt_r + 16'h0001;
          if (su_cnt_r >= su_len) state_r <= CCD_ST_ACTIVE;
        end
        default: state_r <= CCD_ST_ACTIVE;
      endcase
    end
  end

  // level checked at start-up end; a vanished level gives no interrupt
  logic level_irq_r;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) level_irq_r <= 1'b0;
    else level_irq_r <= (state_r == CCD_ST_STARTUP) && (su_cnt_r >= su_len) && level_s;
  end
  assign level_irq_o = level_irq_r;

  // domain run flags from the state and sleep mode
  ccd_dom_t run;
  always_comb begin
    run = '{cpu: 1'b1, flash: 1'b1, io: 1'b1, adc: 1'b1, asy: 1'b1};
    if (state_r != CCD_ST_ACTIVE) run = sleep_domains(mode_r);
    run.flash = run.cpu;
    // async timer runs only when enabled; power-down and standby stop it
    run.asy = run.asy && async_timer_en_i;
    // converter keeps its clock in noise reduction sleep
    if (state_r != CCD_ST_ACTIVE && mode_r == `CCD_SLP_ADC_NR) run.adc = 1'b1;
  end
  assign dom_run_o = run;
  assign asleep_o = (state_r != CCD_ST_ACTIVE);

  // start detector switches to asynchronous mode with io halted
  assign usi_start_async_o = !run.io;

  // gate enables for cpu, flash, io, adc, two-wire address logic
  logic [4:0] gate_want;
  logic [4:0] gate_r;
  // per-domain requests, two-wire never gated by sleep
  assign gate_want = {run.cpu, run.flash, run.io, run.adc, 1'b1} & {5{sys_tick}};
  generate
    for (gi = 0; gi < 5; gi++) begin : g_gate
      // enable updated on the falling edge, so only while clock is low
      always_ff @(negedge ref_clk_i or posedge rst_i) begin
        if (rst_i) gate_r[gi] <= 1'b0;
        else gate_r[gi] <= gate_want[gi];
      end
    end
  endgenerate
  assign dom_clk_o = ccd_clk_t'(gate_r & {5{ref_clk_i}});

  // async timer tick from the external clock rising edge
  logic asy_prev_r;
  logic asy_tick_r;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      asy_prev_r <= 1'b0;
      asy_tick_r <= 1'b0;
    end else begin
      asy_prev_r <= asy_s;
      asy_tick_r <= asy_s && !asy_prev_r && run.asy;
    end
  end
  assign async_timer_tick_o = asy_tick_r;

endmodule : ccd_clock_dist
`default_nettype wire

// ==== verification/ccd_clock_dist_properties.sv ====
// assertion checker bound to the clock domain block
`timescale 1ns/1ps
`default_nettype none
`include "ccd_map.svh"
module ccd_clock_dist_properties #(
  parameter int unsigned SU_16K_CYCLES = 16384,
  parameter int unsigned SU_32K_CYCLES = 32768
) (
  // clock, reset and control
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic sleep_req_i,
  input wire logic [2:0] sleep_mode_i,
  input wire logic wake_pin_i,
  // watched outputs
  input wire ccd_pkg::ccd_clk_t dom_clk_o,
  input wire logic async_timer_tick_o,
  input wire ccd_pkg::ccd_dom_t dom_run_o,
  input wire logic usi_start_async_o,
  input wire logic level_irq_o,
  input wire logic asleep_o
);
  import ccd_pkg::*;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_go(m);
    !asleep_o && sleep_req_i && sleep_mode_i == m;
  endsequence
  sequence s_wake;
    (asleep_o && wake_pin_i) [*4];
  endsequence
  a_usi_async_mode: assert property (usi_start_async_o == !dom_run_o.io)
    else $error("usi mode wrong");
  a_idle_keeps_io: assert property (s_go(`CCD_SLP_IDLE) |=> !dom_run_o.cpu && dom_run_o.io)
    else $error("idle domains wrong");
  a_nr_keeps_adc: assert property (s_go(`CCD_SLP_ADC_NR) |=> !dom_run_o.io && dom_run_o.adc)
    else $error("adc domain wrong");
  a_wake_bounded: assert property (s_wake |-> ##[0:100] !asleep_o)
    else $error("no wake");
  a_irq_one_cycle: assert property (level_irq_o |-> !asleep_o ##1 !level_irq_o)
    else $error("irq pulse wrong");
  a_tick_gated: assert property (!dom_run_o.asy [*4] |-> !async_timer_tick_o)
    else $error("tick while halted");
  // sampled at the end of the low phase
  a_low_phase_quiet: assert property (dom_clk_o == '0)
    else $error("glitch in low phase");
  a_same_rate: assert property (@(negedge ref_clk_i) dom_clk_o.cpu |-> dom_clk_o.flash && dom_clk_o.two_wire_serial_port)
    else $error("domain rates differ");
  a_cpu_halted: assert property (@(negedge ref_clk_i) asleep_o [*2] |-> !dom_clk_o.cpu)
    else $error("cpu clocked in sleep");
endmodule : ccd_clock_dist_properties
bind ccd_clock_dist ccd_clock_dist_properties #(
  .SU_16K_CYCLES(SU_16K_CYCLES), .SU_32K_CYCLES(SU_32K_CYCLES)
) chk_u (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sleep_req_i(sleep_req_i), .sleep_mode_i(sleep_mode_i),
  .wake_pin_i(wake_pin_i), .dom_clk_o(dom_clk_o), .async_timer_tick_o(async_timer_tick_o),
  .dom_run_o(dom_run_o), .usi_start_async_o(usi_start_async_o), .level_irq_o(level_irq_o),
  .asleep_o(asleep_o));
`default_nettype wire

// ==== verification/ccd_domain_loads.sv ====
// modules fed by the domains: count pulses of each gated clock
`timescale 1ns/1ps
`default_nettype none
module ccd_domain_loads (
  // reset and pulses
  input wire logic rst_i,
  input wire logic [5:0] pulse_i,
  // counts
  output logic [15:0] n_o [6]
);
  for (genvar g = 0; g < 6; g++) begin : g_ld
    always_ff @(posedge pulse_i[g] or posedge rst_i) begin
      if (rst_i) n_o[g] <= '0;
      else n_o[g] <= n_o[g] + 16'h1;
    end
  end
endmodule : ccd_domain_loads
`default_nettype wire

// ==== verification/ccd_clock_dist_tb.sv ====
// self-checking bench of the clock domain block
`timescale 1ns/1ps
`default_nettype none
`include "ccd_map.svh"
`define CHK(s, e, a) begin total_checks++; if ((a) !== (e)) begin fail_count++; $display("CHECK FAILED %s exp %h got %h", s, e, a); end end
module ccd_clock_dist_tb;
  import ccd_pkg::*;
  logic ref_clk_i = 0, rst_i = 1, slp = 0, wk = 0, lvl = 0, aclk = 0;
  logic [3:0] fus = 4'h2, psc = 4'h0;
  logic [2:0] md = 3'h0;
  ccd_clk_t clk;
  ccd_dom_t run;
  ccd_osc_t src;
  logic tick, resv, universal_serial_port, irq, asl;
  logic [15:0] n [6];
  int fail_count = 0, total_checks = 0;
  always #25 ref_clk_i = ~ref_clk_i;
  always #400 aclk = ~aclk;
  ccd_clock_dist #(.SU_16K_CYCLES(20), .SU_32K_CYCLES(24)) dut_u (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .clock_source_select_fuses_i(fus),
    .startup_time_fuses_i(2'h2), .prescale_sel_i(psc), .sleep_req_i(slp), .sleep_mode_i(md),
    .async_timer_en_i(1'b1), .wake_pin_i(wk), .level_irq_pin_i(lvl), .async_timer_domain_clock_i(aclk),
    .dom_clk_o(clk), .async_timer_tick_o(tick), .dom_run_o(run), .clock_source_o(src),
    .fuse_reserved_o(resv), .usi_start_async_o(universal_serial_port), .level_irq_o(irq), .asleep_o(asl));
  ccd_domain_loads ld_u (.rst_i(rst_i), .pulse_i({clk, tick}), .n_o(n));
  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk_i);
  endtask : cyc
  task automatic do_reset(input logic [3:0] f);
    fus = f;
    rst_i = 1;
    cyc(2);
    rst_i = 0;
    cyc(2);
  endtask : do_reset
  function automatic ccd_osc_t src_of(input logic [3:0] c);
    if (c >= 4'h8) return CCD_OSC_LP_XTAL;
    if (c >= 4'h6) return CCD_OSC_FS_XTAL;
    if (c >= 4'h4) return CCD_OSC_LF_XTAL;
    if (c == 4'h3) return CCD_OSC_RC128K;
    if (c == 4'h0) return CCD_OSC_EXT;
    return CCD_OSC_RC_CAL;
  endfunction : src_of
  task automatic t_source;
    for (int c = 0; c < 16; c++) begin
      do_reset(c[3:0]);
      `CHK("source", src_of(c[3:0]), src)
      `CHK("reserved", c == 1, resv)
    end
    $display("source test done");
  endtask : t_source
  task automatic t_rate;
    logic [15:0] c0, t0, f0;
    psc = 4'h2;
    cyc(8);
    c0 = n[5];
    t0 = n[1];
    f0 = n[4];
    cyc(40);
    `CHK("cpu rate", 16'h000a, n[5] - c0)
    `CHK("flash rate", 16'h000a, n[4] - f0)
    `CHK("twi rate", 16'h000a, n[1] - t0)
    psc = 4'h0;
    $display("rate test done");
  endtask : t_rate
  task automatic t_sleep;
    logic [2:0] mds [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
    logic [4:0] ex [6] = '{5'h07, 5'h03, 5'h00, 5'h01, 5'h00, 5'h01};
    logic [15:0] c0, i0, a0, t0;
    for (int i = 0; i < 6; i++) begin
      md = mds[i];
      slp = 1;
      cyc(1);
      slp = 0;
      cyc(2);
      c0 = n[5];
      i0 = n[3];
      a0 = n[2];
      t0 = n[0];
      `CHK("run", ex[i], run)
      `CHK("usi async", !ex[i][2], universal_serial_port)
      cyc(40);
      `CHK("cpu held", 1'b1, n[5] == c0)
      `CHK("io", ex[i][2], n[3] != i0)
      `CHK("adc", ex[i][1], n[2] != a0)
      `CHK("tick", ex[i][0], n[0] != t0)
      wk = 1;
      for (int k = 0; k < 100 && asl; k++) cyc(1);
      wk = 0;
      `CHK("awake", 1'b0, asl)
      cyc(4);
    end
    $display("sleep test done");
  endtask : t_sleep
  task automatic t_level(input int hold, input logic exp);
    logic seen;
    seen = 0;
    md = `CCD_SLP_PDOWN;
    slp = 1;
    cyc(1);
    slp = 0;
    cyc(2);
    // the waking source keeps its level for hold cycles
    lvl = 1;
    for (int k = 0; k < 60; k++) begin
      if (k == hold) lvl = 0;
      if (irq === 1'b1) seen = 1;
      cyc(1);
    end
    lvl = 0;
    `CHK("level irq", exp, seen)
    `CHK("woke", 1'b0, asl)
    cyc(4);
    $display("level test done");
  endtask : t_level
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  initial begin
    #200000;
    fail_count++;
    close_out();
  end
  initial begin
    t_source();
    do_reset(4'h2);
    t_rate();
    t_sleep();
    t_level(60, 1'b1);
    t_level(4, 1'b0);
    close_out();
  end
endmodule : ccd_clock_dist_tb
`default_nettype wire
